// file: bench/sacpc_core_asserts.sv
/* Port checker for sacpc_core.
   Assumes the bench strobe pulse spans one SCK period. */
`timescale 1ns/1ps
module sacpc_core_asserts
  import sacpc_pkg::*;
#(parameter int RES_BITS = SACPC_RES_BITS_WIDE) (
  // Watched ports
  input wire logic                clk_sys_in,
  input wire logic                rst_in,
  input wire logic                sck_in,
  input wire logic                conversion_start_strobe_in,
  input wire logic                sdo_out,
  input wire logic                sdo_oe_out,
  input wire logic [RES_BITS-1:0] sample_code_in,
  input wire logic                sample_hold_out,
  input wire logic                reference_on_out,
  input wire logic                bias_on_out,
  input wire logic [1:0]          power_state_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence s_held(logic [1:0] v);
    (power_state_out == v)[*3];
  endsequence
  chk_sdo_idle_low: assert property (!sdo_oe_out |-> !sdo_out)
    else $error("sdo high while released");
  chk_first_bit: assert property ($rose(sdo_oe_out) |-> sck_in && sample_hold_out)
    else $error("sdo drive began off an SCK rise");
  chk_bit_on_rise: assert property ($changed(sdo_out) && sdo_oe_out && $past(sdo_oe_out) |-> sck_in)
    else $error("sdo bit changed off an SCK rise");
  chk_hold_end: assert property ($fell(sample_hold_out) |-> sck_in)
    else $error("hold ended off an SCK rise");
  chk_active_on: assert property (s_held(2'h0) |-> bias_on_out && reference_on_out)
    else $error("power off while active");
  chk_nap_ref: assert property (s_held(2'h1) |-> reference_on_out && !bias_on_out)
    else $error("wrong power switches in nap");
  chk_sleep_off: assert property (s_held(2'h2) |-> !reference_on_out && !bias_on_out)
    else $error("power left on in sleep");
  chk_wake_sck: assert property ($changed(power_state_out) && power_state_out == 2'h0 |-> sck_in)
    else $error("woke without SCK");
  chk_down_strobe: assert property ($changed(power_state_out) && power_state_out != 2'h0 |-> conversion_start_strobe_in)
    else $error("powered down without strobe");
  chk_release_rise: assert property ($fell(sdo_oe_out) |-> sck_in)
    else $error("sdo released off an SCK rise");
endmodule // sacpc_core_asserts

// file: bench/sacpc_host.sv
/* Host serial port model: drives SCK and strobe, captures SDO.
   Assumes clk_sys_in at 100 MHz; SCK idles low between frames. */
`timescale 1ns/1ps
module sacpc_host (
  // Clock and link
  input  wire logic clk_sys_in,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in,
  output logic      sck_out,
  output logic      strobe_out
);
  logic        last_q;
  logic [15:0] word_q;
  logic        line;
  // Released line floats to a changing level
  assign line = sdo_oe_in ? sdo_in : ~last_q;
  initial begin
    sck_out = 1'b0;
    strobe_out = 1'b0;
    last_q = 1'b0;
    word_q = 16'h0000;
  end
  always @(negedge sck_out) begin
    word_q <= {word_q[14:0], line};
    last_q <= line;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic sck_n(input int n);
    repeat (n) begin
      wait_clk(8);
      sck_out = 1'b1;
      wait_clk(8);
      sck_out = 1'b0;
    end
  endtask
  task automatic strobe();
    wait_clk(8);
    strobe_out = 1'b1;
    wait_clk(16);
    strobe_out = 1'b0;
  endtask
endmodule // sacpc_host

// file: bench/tb_sacpc_core.sv
/* Testbench for sacpc_core with the host model.
   Assumes the 14-bit default width. */
`timescale 1ns/1ps
module tb_sacpc_core;
  import sacpc_pkg::*;
  logic        clk_sys_in, rst_in, sck, strobe, sdo, sdo_oe;
  logic        hold, ref_on, bias_on;
  logic [13:0] code;
  logic [1:0]  pwr;
  int          errors, n_tests;
  sacpc_core sacpc_core_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .sck_in(sck),
    .conversion_start_strobe_in(strobe), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .sample_code_in(code), .sample_hold_out(hold),
    .reference_on_out(ref_on), .bias_on_out(bias_on),
    .power_state_out(pwr));
  sacpc_host sacpc_host_i (.clk_sys_in(clk_sys_in), .sdo_in(sdo),
    .sdo_oe_in(sdo_oe),
    .sck_out(sck), .strobe_out(strobe));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst_in = 1'b1;
    sacpc_host_i.wait_clk(10);
    rst_in = 1'b0;
    check({pwr, sdo_oe, ref_on, bias_on}, 16'h0003);
  endtask
  task automatic t_conversion_start_strobe(input logic [13:0] v, input bit extra);
    int i;
    code = v;
    sacpc_host_i.strobe();
    for (i = 0; i < 10 && hold !== 1'b1; i++) sacpc_host_i.wait_clk(1);
    check(hold, 1);
    sacpc_host_i.sck_n(5);
    if (extra) sacpc_host_i.strobe();
    sacpc_host_i.sck_n(11);
    // Let the capture on the last SCK fall land
    sacpc_host_i.wait_clk(1);
    check(sacpc_host_i.word_q[13:0], v);
    sacpc_host_i.sck_n(1);
    check({hold, sdo_oe, pwr}, 0);
    sacpc_host_i.sck_n(1);
  endtask
  task automatic t_power(input bit deep);
    repeat (2) sacpc_host_i.strobe();
    check({pwr, ref_on, bias_on}, {SACPC_PWR_NAP, 2'b10});
    if (deep) begin
      repeat (2) sacpc_host_i.strobe();
      check({pwr, ref_on, bias_on}, {SACPC_PWR_SLEEP, 2'b00});
    end
    sacpc_host_i.sck_n(1);
    check({pwr, ref_on, bias_on}, {SACPC_PWR_ACTIVE, 2'b11});
    sacpc_host_i.sck_n(17);
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    errors++;
    end_sim();
  end
  initial begin
    errors = 0;
    n_tests = 0;
    code = 14'h0000;
    do_reset();
    t_conversion_start_strobe(14'h3FFF, 1'b0);
    t_conversion_start_strobe(14'h0000, 1'b1);
    t_conversion_start_strobe(14'h2A5C, 1'b1);
    t_power(1'b0);
    t_conversion_start_strobe(14'h1001, 1'b0);
    // Single sleep entry per run; no accuracy relied on after it
    t_power(1'b1);
    do_reset();
    t_conversion_start_strobe(14'h0ACE, 1'b0);
    end_sim();
  end
endmodule // tb_sacpc_core
bind sacpc_core sacpc_core_asserts #(.RES_BITS(RES_BITS)) sacpc_core_asserts_i (
  .clk_sys_in                 (clk_sys_in),
  .rst_in                     (rst_in),
  .sck_in                     (sck_in),
  .conversion_start_strobe_in (conversion_start_strobe_in),
  .sdo_out                    (sdo_out),
  .sdo_oe_out                 (sdo_oe_out),
  .sample_code_in             (sample_code_in),
  .sample_hold_out            (sample_hold_out),
  .reference_on_out           (reference_on_out),
  .bias_on_out                (bias_on_out),
  .power_state_out            (power_state_out));

// file: hw/sacpc_core.sv
/*
  Digital control of a sampling converter with a three-wire serial port:
  conversion start, result shift-out on SDO, nap and sleep power-down.
  Assumes the host drives the strobe and SCK; both are sampled by clk_sys_in.
*/
`timescale 1ns/1ps
module sacpc_core
  import sacpc_pkg::*;
#(
  parameter int RES_BITS = SACPC_RES_BITS_WIDE
) (
  // Clock and reset
  input  wire logic                clk_sys_in,
  input  wire logic                rst_in,
  // Serial link pins
  input  wire logic                sck_in,
  input  wire logic                conversion_start_strobe_in,
  output logic                     sdo_out,
  output logic                     sdo_oe_out,
  // Converter core
  input  wire logic [RES_BITS-1:0] sample_code_in,
  output logic                     sample_hold_out,
  output logic                     reference_on_out,
  output logic                     bias_on_out,
  output logic [1:0]               power_state_out
);
  // ********************************************************
  // Parameter check
  // ********************************************************
  // Refuse widths the 16-rise frame cannot carry and strobe counts the run counter cannot hold
  if (RES_BITS != SACPC_RES_BITS_WIDE &&
      RES_BITS != SACPC_RES_BITS_NARROW) begin : gen_bad_width
    $error("RES_BITS must be 12 or 14");
  end
  if (SACPC_FIRST_BIT_EDGE + RES_BITS - 1 >
      SACPC_BUSY_EDGES) begin : gen_bad_frame
    $error("result does not fit in the busy window");
  end
  if (SACPC_SLEEP_STROBES <= SACPC_NAP_STROBES ||
      SACPC_SLEEP_STROBES > 7) begin : gen_bad_strobes
    $error("strobe counts do not fit the run counter");
  end

  // One code step is the full span over this many codes
  localparam int LSB_DIV = (RES_BITS == SACPC_RES_BITS_WIDE) ?
                           SACPC_LSB_DIV_WIDE : SACPC_LSB_DIV_NARROW;
  localparam logic [4:0] BUSY_EDGES = 5'(SACPC_BUSY_EDGES);
  localparam logic [4:0] FIRST_EDGE = 5'(SACPC_FIRST_BIT_EDGE);
  localparam logic [4:0] LAST_EDGE  = 5'(SACPC_FIRST_BIT_EDGE + RES_BITS - 1);
  localparam logic [2:0] NAP_CNT    = 3'(SACPC_NAP_STROBES);
  localparam logic [2:0] SLEEP_CNT  = 3'(SACPC_SLEEP_STROBES);

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic sck_level;
  logic sck_rise;
  logic strobe_level;
  logic strobe_rise;

  sacpc_sync u_sck_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (sck_in),
    .level_out  (sck_level),
    .rise_out   (sck_rise)
  );

  sacpc_sync u_strobe_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .async_in   (conversion_start_strobe_in),
    .level_out  (strobe_level),
    .rise_out   (strobe_rise)
  );

  // ********************************************************
  // Conversion frame decode
  // ********************************************************
  logic [4:0] edge_next;
  logic       bit_window;
  logic       frame_done;
  logic [2:0] run_next;
  logic       run_sleep;
  logic       run_nap;

  // SCK rise count as it stands after this rise
  assign edge_next  = state_q.edges + 5'h01;
  // Result bits go out on rises FIRST_EDGE through LAST_EDGE
  assign bit_window = (edge_next >= FIRST_EDGE) &&
                      (edge_next <= LAST_EDGE);
  assign frame_done = (edge_next == BUSY_EDGES);
  // Run counter saturates so a long run stays in sleep
  assign run_next   = (state_q.strobes == SLEEP_CNT) ?
                      state_q.strobes : state_q.strobes + 3'h1;
  assign run_sleep  = (run_next >= SLEEP_CNT);
  assign run_nap    = (run_next >= NAP_CNT);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    sacpc_pwr_type       pwr;
    logic                busy;
    logic [4:0]          edges;
    logic [2:0]          strobes;
    logic [RES_BITS-1:0] shreg;
    logic                sdo;
    logic                sdo_oe;
    logic                hold;
    logic                ref_on;
    logic                bias_on;
    logic [1:0]          pwr_out;
  } sacpc_core_type;

  sacpc_core_type state_q;
  sacpc_core_type state_d;

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    state_d = state_q;
    // Power switch outputs follow the power state one clock later
    state_d.ref_on  = (state_q.pwr != SACPC_PWR_SLEEP);
    state_d.bias_on = (state_q.pwr == SACPC_PWR_ACTIVE);
    state_d.pwr_out = state_q.pwr;
    if (sck_rise) begin
      // Any SCK rise wakes and clears the strobe run
      state_d.strobes = 3'h0;
      state_d.pwr     = SACPC_PWR_ACTIVE;
      if (state_q.busy) begin
        state_d.edges = edge_next;
        if (bit_window) begin
          state_d.sdo    = state_q.shreg[RES_BITS-1];
          state_d.shreg  = {state_q.shreg[RES_BITS-2:0], 1'b0};
          state_d.sdo_oe = 1'b1;
        end else begin
          state_d.sdo    = 1'b0;
          state_d.sdo_oe = 1'b0;
        end
        if (frame_done) begin
          // Tracking resumes; strobes are honoured again
          state_d.busy = 1'b0;
          state_d.hold = 1'b0;
        end
      end else begin
        // First rise after the frame releases the last bit
        state_d.sdo    = 1'b0;
        state_d.sdo_oe = 1'b0;
      end
    end else if (strobe_rise) begin
      state_d.strobes = run_next;
      if (run_sleep) begin
        state_d.pwr = SACPC_PWR_SLEEP;
      end else if (run_nap) begin
        state_d.pwr = SACPC_PWR_NAP;
      end
      if (!state_q.busy) begin
        // Start: hold sample, load natural binary code
        state_d.busy  = 1'b1;
        state_d.edges = SACPC_CNT_RESET;
        state_d.hold  = 1'b1;
        state_d.shreg = sample_code_in;
      end
    end
  end

  // ********************************************************
  // Register update
  // ********************************************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q.pwr     <= SACPC_PWR_ACTIVE;
      state_q.busy    <= 1'b0;
      state_q.edges   <= SACPC_CNT_RESET;
      state_q.strobes <= 3'h0;
      state_q.shreg   <= '0;
      state_q.sdo     <= 1'b0;
      state_q.sdo_oe  <= 1'b0;
      state_q.hold    <= 1'b0;
      state_q.ref_on  <= 1'b1;
      state_q.bias_on <= 1'b1;
      state_q.pwr_out <= 2'h0;
    end else begin
      state_q <= state_d;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  // All outputs come straight from state flops
  assign sdo_out          = state_q.sdo;
  assign sdo_oe_out       = state_q.sdo_oe;
  assign sample_hold_out  = state_q.hold;
  assign reference_on_out = state_q.ref_on;
  assign bias_on_out      = state_q.bias_on;
  assign power_state_out  = state_q.pwr_out;

  // Pin levels and the code step are not needed by this logic
  logic unused_levels;
  assign unused_levels = sck_level ^ strobe_level ^ (LSB_DIV == 0);
endmodule // sacpc_core

// file: hw/sacpc_sync.sv
/*
  Three-stage synchroniser with edge report on agreement of stages two and
  three. Assumes the input is asynchronous to clk_sys_in.
*/
`timescale 1ns/1ps
module sacpc_sync (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // Asynchronous input
  input  wire logic async_in,
  // Synchronised outputs
  output logic      level_out,
  output logic      rise_out
);
  typedef struct packed {
    logic [2:0] stages;
    logic       level;
    logic       rise;
  } sacpc_sync_type;

  sacpc_sync_type state_q;
  sacpc_sync_type state_d;

  always_comb begin
    state_d        = state_q;
    state_d.stages = {state_q.stages[1:0], async_in};
    state_d.rise   = 1'b0;
    if (state_q.stages[2] == state_q.stages[1] &&
        state_q.stages[2] != state_q.level) begin
      state_d.level = state_q.stages[2];
      state_d.rise  = state_q.stages[2];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign level_out = state_q.level;
  assign rise_out  = state_q.rise;
endmodule // sacpc_sync

// file: inc/sacpc_pkg.sv
/*
  Constants for the serial converter conversion and power control block.
  Assumes a 100 MHz system clock that samples the serial clock and strobe.
*/
package sacpc_pkg;
  // ********************************************************
  // Timing and widths
  // ********************************************************
  localparam int SACPC_CLK_PERIOD_NS   = 10;
  localparam int SACPC_RES_BITS_WIDE   = 14;
  localparam int SACPC_RES_BITS_NARROW = 12;
  localparam int SACPC_LSB_DIV_WIDE    = 16384;
  localparam int SACPC_LSB_DIV_NARROW  = 4096;
  localparam int SACPC_BUSY_EDGES      = 16;
  localparam int SACPC_FIRST_BIT_EDGE  = 3;
  localparam int SACPC_NAP_STROBES     = 2;
  localparam int SACPC_SLEEP_STROBES   = 4;
  localparam int SACPC_SYNC_STAGES     = 3;
  localparam logic [4:0] SACPC_CNT_RESET = 5'h00;

  // ********************************************************
  // Power states
  // ********************************************************
  typedef enum logic [1:0] {
    SACPC_PWR_ACTIVE,
    SACPC_PWR_NAP,
    SACPC_PWR_SLEEP
  } sacpc_pwr_type;
endpackage
